// file: sapr_port.sv
// Result buffer and the converter control / parallel result port.
`timescale 1ns/1ps

// Small FIFO of flip-flops with valid/ready on both sides.
module sapr_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage, pointers and fill level.
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // Full and empty follow the fill count directly, so they never lie.
  always_comb
  begin
    in_ready = (cnt_ff != (AW+1)'(DEPTH));
    out_valid = (cnt_ff != '0);
    out_data = mem_ff[rd_ff];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wr = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointers and count are registered; storage is written on push only.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
    if (push)
    begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule // sapr_fifo

// Conversion sequencer and three-state result bus driver.
module sapr_port
  import sapr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic conversion_trigger_n,
  input wire logic rd_n,
  input wire logic half_sel,
  input wire logic [15:0] sar_code,
  output logic busy,
  output logic [15:0] result_bus_o,
  output logic result_bus_oe
);
  // Two-stage synchronisers for the host pins; stage one feeds stage two only.
  sapr_pins_s meta_ff, sync_ff, prev_ff;
  // Sequencer state and conversion cycle counter.
  sapr_state_e state_ff, nxt_state;
  logic [4:0] cyc_ff, nxt_cyc;
  // Result held for the host, and the registered pin drivers.
  logic [15:0] result_ff, nxt_result;
  logic busy_ff, nxt_busy;
  logic [15:0] bus_ff, nxt_bus;
  logic oe_ff, nxt_oe;
  // Buffer handshakes.
  logic push_valid, push_ready, head_valid, head_ready;
  logic [15:0] head_data;
  logic trig_fall, cs_fall, conv_done, read_on;

  // Pin synchronisers; the previous copy supports edge detection.
  // Reset loads every stage with the idle level of its pin, so the edge
  // detectors cannot report a false edge in the cycles after reset.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      meta_ff <= '{cs_n: 1'b1, trig_n: 1'b1, rd_n: 1'b1, half_sel: 1'b0};
      sync_ff <= '{cs_n: 1'b1, trig_n: 1'b1, rd_n: 1'b1, half_sel: 1'b0};
      prev_ff <= '{cs_n: 1'b1, trig_n: 1'b1, rd_n: 1'b1, half_sel: 1'b0};
    end
    else
    begin
      meta_ff <= '{cs_n: cs_n, trig_n: conversion_trigger_n, rd_n: rd_n, half_sel: half_sel};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Completed codes wait here; a stalled read holds them back.
  sapr_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(sar_code),
    .out_valid(head_valid),
    .out_ready(head_ready),
    .out_data(head_data)
  );

  // Sequencer, result hand-off and bus driver next values.
  always_comb
  begin
    trig_fall = prev_ff.trig_n && !sync_ff.trig_n;
    cs_fall = prev_ff.cs_n && !sync_ff.cs_n;
    read_on = !sync_ff.cs_n && !sync_ff.rd_n;
    conv_done = (state_ff == ST_CONV) && (cyc_ff == CONV_LAST);
    // A full buffer holds the last cycle of conversion until room appears.
    push_valid = conv_done;
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    unique case (state_ff)
      ST_IDLE, ST_ACQ:
      begin
        if (trig_fall)
        begin
          // Hold phase begins and the conversion is timed internally.
          nxt_state = ST_CONV;
          nxt_cyc = '0;
        end
        else if (cs_fall)
        begin
          nxt_state = ST_ACQ;
        end
      end
      ST_CONV:
      begin
        if (trig_fall)
        begin
          // A new trigger restarts the count; the old code is abandoned unless the trigger lands on the last cycle with room in the buffer.
          nxt_cyc = '0;
        end
        else if (conv_done)
        begin
          if (push_ready)
          begin
            nxt_state = ST_IDLE;
          end
        end
        else
        begin
          nxt_cyc = 5'(cyc_ff + 1'b1);
        end
      end
    endcase
    // The held result never changes under a host that is reading it.
    // A stalled head stays in the buffer until the read has ended.
    head_ready = !read_on;
    nxt_result = (head_valid && head_ready) ? head_data : result_ff;
    // Busy stays high until the code has reached the held result, so the
    // data is already valid when busy falls.
    // The push cycle counts as busy: at that edge the code only enters the
    // buffer, and the held result loads one edge later, so busy bridges
    // both cycles instead of dipping low and rising again for one cycle.
    // A code waiting at the buffer head also keeps busy high, which tells a
    // host that is still reading the old result that a new one is pending.
    // The cost is two extra cycles of busy after the count has finished.
    nxt_busy = (nxt_state == ST_CONV) || conv_done || head_valid;
    // Output enable follows select and strobe; release on either rising.
    nxt_oe = read_on;
    if (sync_ff.half_sel)
    begin
      // Folded view for an eight-bit host; the half select is read every
      // cycle so a change re-drives the bus without a new strobe.
      nxt_bus = {result_ff[FOLD_HI:FOLD_LO], {(RES_W-FOLD_W){1'b1}}};
    end
    else
    begin
      nxt_bus = result_ff;
    end
  end

  // State registers and pin drivers.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      cyc_ff <= '0;
      result_ff <= RES_RST;
      busy_ff <= 1'b0;
      bus_ff <= RES_RST;
      oe_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      result_ff <= nxt_result;
      busy_ff <= nxt_busy;
      bus_ff <= nxt_bus;
      oe_ff <= nxt_oe;
    end
  end

  // Every output comes straight from a flip-flop.
  // The data word is driven even while the enable is low; the pad stage
  // uses the enable to float the pins, so the word itself never glitches.
  assign busy = busy_ff;
  assign result_bus_o = bus_ff;
  assign result_bus_oe = oe_ff;
endmodule // sapr_port

// file: sapr_pkg.sv
// Shared constants and types for the converter control and parallel result port.
// Contract
// - Busy high throughout conversion, low otherwise; code stays busy two extra cycles and while a buffered code waits.
// - Trigger falling edge ends acquisition, starts hold.
// - Chip-select falling edge starts acquisition.
// - Half select low: full result, no folding.
// - Half select high: bits 7..2 high, rest ones.
// - Half select change re-drives bus, no strobe.
// - Bus released soon after strobe or select rises.
// - Result valid no later than busy falling.
// - Select and strobe low enable the result.
// - Internal conversion finishes within 650 ns.
package sapr_pkg;
  // Width of one conversion result.
  localparam int RES_W = 16;
  // Depth of the result buffer between core and port.
  localparam int FIFO_DEPTH = 8;
  // Clock rate and the longest conversion time.
  localparam int CLK_MHZ = 40;
  localparam int CONV_NS = 650;
  // Longest time rounds down to whole cycles.
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam logic [4:0] CONV_LAST = 5'(CONV_CYC - 1);
  // Field positions for the folded half-word view.
  localparam int FOLD_HI = 7;
  localparam int FOLD_LO = 2;
  localparam int FOLD_W = FOLD_HI - FOLD_LO + 1;
  // Value of the result register after reset.
  localparam logic [15:0] RES_RST = 16'h0000;
  // Host-side control pins as sampled inside the clock domain.
  typedef struct packed {
    logic cs_n;
    logic trig_n;
    logic rd_n;
    logic half_sel;
  } sapr_pins_s;
  // Converter sequence states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10
  } sapr_state_e;
endpackage

// file: sapr_port_props.sv
// Pin-level checks of the result port.
`timescale 1ns/1ps
module sapr_port_props
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic conversion_trigger_n,
  input wire logic rd_n,
  input wire logic half_sel,
  input wire logic busy,
  input wire logic [15:0] result_bus_o,
  input wire logic result_bus_oe
);
  // Pins pass a synchroniser, so reactions get a few cycles.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_go; $fell(conversion_trigger_n) && !busy |-> ##[2:5] busy; endproperty
  a_go: assert property (p_go) else $error("busy late");
  property p_len; $rose(busy) |-> busy[*8]; endproperty
  a_len: assert property (p_len) else $error("busy short");
  property p_max; $rose(busy) |-> ##[20:99] !busy; endproperty
  a_max: assert property (p_max) else $error("busy long");
  property p_rest; (!busy && conversion_trigger_n)[*6] |=> !busy; endproperty
  a_rest: assert property (p_rest) else $error("busy unasked");
  property p_on; (!cs_n && !rd_n && !busy)[*5] |-> result_bus_oe; endproperty
  a_on: assert property (p_on) else $error("bus not driven");
  property p_off; rd_n[*5] |-> !result_bus_oe; endproperty
  a_off: assert property (p_off) else $error("bus held");
  property p_fold; (half_sel && result_bus_oe)[*5] |-> &result_bus_o[9:0]; endproperty
  a_fold: assert property (p_fold) else $error("fold low bits");
  property p_redo; $rose(half_sel) && result_bus_oe |-> ##[1:5] &result_bus_o[9:0]; endproperty
  a_redo: assert property (p_redo) else $error("no redrive");
endmodule // sapr_port_props

// file: sapr_host.sv
// Host model driving the converter control pins.
`timescale 1ns/1ps
module sapr_host
(
  input wire logic clock,
  output logic cs_n,
  output logic conversion_trigger_n,
  output logic rd_n,
  output logic half_sel
);
  // Idle deselected, full-width view.
  initial {cs_n, conversion_trigger_n, rd_n, half_sel} = 4'hE;
  // Change pins after a falling edge and hold them n cycles.
  task automatic pins(input logic [3:0] v, input int n);
    @(negedge clock);
    {cs_n, conversion_trigger_n, rd_n, half_sel} = v;
    repeat (n - 1) @(negedge clock);
  endtask
  // Acquire, trigger; an abort triggers again 200 ns later.
  task automatic conv(input logic ab);
    pins(4'h6, 13);
    pins(4'h2, 4);
    pins(4'h6, 4);
    if (ab)
      pins(4'h2, 4);
    pins(4'h6, 1);
  endtask
  // Read for six cycles with half select h; the caller waits for busy to fall.
  task automatic rd(input logic h);
    pins({3'b010, h}, 6);
  endtask
  // Release the read long before the next trigger.
  task automatic idle;
    pins(4'hE, 5);
  endtask
endmodule // sapr_host

// file: sapr_port_tb_top.sv
// Self-checking bench for the result port.
`timescale 1ns/1ps
module sapr_port_tb_top;
  import sapr_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] sar_code = 16'h0000;
  logic cs_n, conversion_trigger_n, rd_n, half_sel, busy, result_bus_oe;
  logic [15:0] result_bus_o, c;
  logic [31:0] s = 32'hDF30;
  logic [15:0] q[$]; // Codes converted but not yet read.
  int fail_count = 0;
  int cmp_count = 0;
  sapr_host sapr_host_i (.clock, .cs_n, .conversion_trigger_n, .rd_n, .half_sel);
  sapr_port sapr_port_i (.clock, .reset_n, .cs_n, .conversion_trigger_n, .rd_n, .half_sel,
    .sar_code, .busy, .result_bus_o, .result_bus_oe);
  initial forever #12.5 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [RES_W-1:0] a, input logic [RES_W-1:0] e);
    cmp_count++;
    if (a !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t saw %h want %h", $time, a, e);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Convert random codes, one aborted, reading each in both halves.
  initial
  begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    chk(busy, 1'b0);
    chk(result_bus_oe, 1'b0);
    chk(result_bus_o, RES_RST);
    for (int i = 0; i < 6; i++)
    begin
      s = xs(s);
      sar_code = s[15:0];
      q.push_back(s[15:0]);
      sapr_host_i.conv(i == 2);
      chk(busy, 1'b1);
      for (int k = 0; k < 99 && busy !== 1'b0; k++)
        @(negedge clock);
      chk(busy, 1'b0);
      c = q.pop_front();
      chk(result_bus_o, c);
      sapr_host_i.rd(1'b0);
      chk(result_bus_o, c);
      sapr_host_i.rd(1'b1);
      chk(result_bus_o, {c[7:2], 10'h3FF});
      sapr_host_i.idle();
      chk(result_bus_oe, 1'b0);
    end
    close_out();
  end
  // Cut a hang short.
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule // sapr_port_tb_top
bind sapr_port sapr_port_props sapr_port_props_i (.clock, .reset_n, .cs_n,
  .conversion_trigger_n, .rd_n, .half_sel, .busy, .result_bus_o, .result_bus_oe);
